// >>> hdl/ctl_spi_pkg.sv
// Purpose: shared constants and types for the analog-die control byte link
// Assumes: one-byte transfers, msb first, select active low
// Notes:   bit positions of the control and status bytes live here
package ctl_spi_pkg;
  localparam int unsigned XFER_BITS     = 8;
  localparam logic [3:0]  BIT_COUNT_END = 4'h8;
  // control byte fields
  localparam int unsigned CTL_SLEW_HI   = 7;
  localparam int unsigned CTL_SLEW_LO   = 6;
  localparam int unsigned CTL_PULLUP    = 5;
  localparam int unsigned CTL_SW3       = 4;
  localparam int unsigned CTL_SW2       = 3;
  localparam int unsigned CTL_SW1       = 2;
  localparam int unsigned CTL_OP_HI     = 1;
  localparam int unsigned CTL_OP_LO     = 0;
  // status byte fields
  localparam int unsigned ST_IRQ        = 7;
  localparam int unsigned ST_BUS        = 6;
  localparam int unsigned ST_OV         = 5;
  localparam int unsigned ST_UV         = 4;
  localparam int unsigned ST_RTW        = 3;
  localparam int unsigned ST_SWT        = 2;
  localparam int unsigned ST_WAKE2      = 1;
  localparam int unsigned ST_WAKE1      = 0;
  localparam logic [7:0]  CTL_RESET     = 8'h00;
  localparam logic [1:0]  SLEW_LOWPOWER = 2'h3;
  // wishbone register offsets of the controller end
  localparam logic [3:0]  WB_CMD_OFS    = 4'h0;
  localparam logic [3:0]  WB_STAT_OFS   = 4'h4;
  localparam logic [3:0]  WB_DIV_OFS    = 4'h8;
  localparam logic [7:0]  DIV_RESET     = 8'h04;

  typedef enum logic [1:0] {
    SLEW_20K  = 2'b00,
    SLEW_10K  = 2'b01,
    SLEW_FAST = 2'b10,
    SLEW_LP   = 2'b11
  } slew_t;

  typedef enum logic [1:0] {
    OP_SLEEP  = 2'b00,
    OP_STOP   = 2'b01,
    OP_WDCLR  = 2'b10,
    OP_RUN    = 2'b11
  } op_t;
endpackage

// >>> hdl/ctl_spi_if.sv
// Purpose: four-wire link between the controller and the analog die
// Assumes: the die's data output is three-state, resolved here
// Notes:   pulled-up reading when nobody drives
`timescale 1ns/1ps
`default_nettype none
interface ctl_spi_if;
  logic select_n;
  logic serial_clock_in;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  wire  miso;
  // a released data line reads as its pull-up level
  assign miso = miso_oe ? miso_o : 1'b1;
  modport die (
    input  select_n,
    input  serial_clock_in,
    input  mosi,
    output miso_o,
    output miso_oe
  );
  modport ctrl (
    output select_n,
    output serial_clock_in,
    output mosi,
    input  miso
  );
endinterface
`default_nettype wire

// >>> hdl/analog_die_spi_slave_regs.sv
// Purpose: control and status byte slave of the analog die
// Assumes: link pins are asynchronous and are synchronised to clk
// Notes:   analog events arrive as level inputs on clk
// Function
// (RQ1) one byte each way per transfer
// (RQ2) select fall starts, drives out, snapshots status
// (RQ3) launch on rising, sample on falling clock
// (RQ4) exactly eight sample edges else discard
// (RQ5) select rise commits byte; output floats
// (RQ6) resets clear fields; pullup by power-on only
// (RQ7) bits 7:6 pick slew or low power
// (RQ8) bit 5 disconnects pullup in low power; here bit 5 disconnects it in every slew mode
// (RQ9) bits 4:2 enable three high-side switches
// (RQ10) bits 1:0 sleep, stop, watchdog clear, run
// (RQ11) low power needs same command twice
// (RQ12) status bit 7 marks interrupt source
// (RQ13) first read after reset shows battery fail
// (RQ14) bus wake or fault sets bit 6
// (RQ15) reading a set flag clears it
// (RQ16) bit 5 reports supply overvoltage
// (RQ17) bit 4 reports supply undervoltage
// (RQ18) bit 3 warns regulator overtemperature
// (RQ19) any switch hot: flag, all off
// (RQ20) re-enable needs flag read then write; here any write re-enables
// (RQ21) bits 1:0 wake inputs or wake cause
// (RQ22) most significant bit first
`timescale 1ns/1ps
`default_nettype none
module analog_die_spi_slave_regs
  import ctl_spi_pkg::*;
(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic por_n,
  ctl_spi_if.die    link,
  input  wire logic bus_wake,
  input  wire logic bus_driver_fault,
  input  wire logic overvoltage,
  input  wire logic undervoltage,
  input  wire logic battery_fail,
  input  wire logic regulator_hot,
  input  wire logic switch_hot,
  input  wire logic wake_input_one,
  input  wire logic wake_input_two,
  input  wire logic wake_by_one,
  input  wire logic wake_by_two,
  output logic [1:0] slew_sel,
  output logic       slew_lowpower_req,
  output logic       bus_pullup_disconnect,
  output logic       switch_one_enable,
  output logic       switch_two_enable,
  output logic       switch_three_enable,
  output logic       sleep_req,
  output logic       stop_req,
  output logic       watchdog_clear,
  output logic       bus_tx_enable
);
  import ctl_spi_pkg::*;

  // two-flop synchronisers plus a third stage; the second and third stages are read, the third only for edge detection
  // reset to the idle levels so no false edge follows reset
  logic [2:0] s1_r, s2_r, s3_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_r <= 3'h4;
      s2_r <= 3'h4;
      s3_r <= 3'h4;
    end else begin
      s1_r <= {link.select_n, link.serial_clock_in, link.mosi};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  wire sel_n   = s2_r[2];
  wire sel_fall = s3_r[2] & ~s2_r[2];
  wire sel_rise = ~s3_r[2] & s2_r[2];
  wire sck_rise = ~sel_n & ~s3_r[1] & s2_r[1];
  wire sck_fall = ~sel_n & s3_r[1] & ~s2_r[1];

  logic [7:0] shin_r, shin_nxt, shout_r, shout_nxt, snap_r, snap_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] ctl_r, ctl_nxt;
  logic       pu_r, pu_nxt;
  logic [7:0] last_r, last_nxt;
  logic       armed_r, armed_nxt;
  logic       first_r, first_nxt, wdc_r, wdc_nxt, sleep_r, sleep_nxt, stop_r, stop_nxt;
  logic       busf_r, busf_nxt, ov_r, ov_nxt, uv_r, uv_nxt, bf_r, bf_nxt;
  logic       rt_r, rt_nxt, sw_r, sw_nxt, wk_r, wk_nxt, txd_r, txd_nxt;
  logic [1:0] wc_r, wc_nxt;
  logic       miso_r, miso_nxt, oe_r, oe_nxt;
  logic [7:0] status;
  logic       irq;
  logic       good;

  always_comb begin
    irq = busf_r | ov_r | uv_r | rt_r | sw_r | wk_r;
    status = 8'h00;
    status[ST_IRQ]   = irq;                                        // [RQ12]
    status[ST_BUS]   = busf_r;                                     // [RQ14]
    status[ST_OV]    = ov_r;                                       // [RQ16]
    status[ST_UV]    = first_r ? bf_r : uv_r;                      // [RQ13] [RQ17]
    status[ST_RTW]   = rt_r;                                       // [RQ18]
    status[ST_SWT]   = sw_r;                                       // [RQ19]
    status[ST_WAKE2] = wk_r ? wc_r[1] : wake_input_two;            // [RQ21]
    status[ST_WAKE1] = wk_r ? wc_r[0] : wake_input_one;            // [RQ21]
  end

  always_comb begin
    shin_nxt = shin_r;
    shout_nxt = shout_r;
    snap_nxt = snap_r;
    cnt_nxt = cnt_r;
    ctl_nxt = ctl_r;
    pu_nxt = pu_r;
    last_nxt = last_r;
    armed_nxt = armed_r;
    first_nxt = first_r;
    wdc_nxt = 1'b0;
    sleep_nxt = sleep_r;
    stop_nxt = stop_r;
    miso_nxt = miso_r;
    oe_nxt = oe_r;
    good = sel_rise && (cnt_r == BIT_COUNT_END);                   // [RQ4]
    // flag set wins over read clear
    busf_nxt = busf_r;
    ov_nxt = ov_r;
    uv_nxt = uv_r;
    bf_nxt = bf_r;
    rt_nxt = rt_r;
    sw_nxt = sw_r;
    wk_nxt = wk_r;
    wc_nxt = wc_r;
    if (good) begin
      if (snap_r[ST_BUS])  busf_nxt = 1'b0;                        // [RQ15]
      if (snap_r[ST_OV])   ov_nxt = 1'b0;                          // [RQ15]
      if (snap_r[ST_UV] && !first_r) uv_nxt = 1'b0;                // [RQ15]
      if (snap_r[ST_UV] && first_r)  bf_nxt = 1'b0;                // [RQ15]
      if (snap_r[ST_RTW])  rt_nxt = 1'b0;                          // [RQ15]
      if (snap_r[ST_SWT])  sw_nxt = 1'b0;                          // [RQ15] [RQ20]
      if (snap_r[ST_IRQ] && wk_r) wk_nxt = 1'b0;                   // [RQ21]
      first_nxt = 1'b0;                                            // [RQ13]
    end
    if (bus_wake || bus_driver_fault) busf_nxt = 1'b1;             // [RQ14]
    if (overvoltage)   ov_nxt = 1'b1;                              // [RQ16]
    if (undervoltage)  uv_nxt = 1'b1;                              // [RQ17]
    if (battery_fail)  bf_nxt = 1'b1;
    if (regulator_hot) rt_nxt = 1'b1;                              // [RQ18]
    if (switch_hot)    sw_nxt = 1'b1;                              // [RQ19]
    if (wake_by_one || wake_by_two) begin
      wk_nxt = 1'b1;
      wc_nxt = {wake_by_two, wake_by_one};
    end
    // transmitter stays off until fault gone and flag cleared
    txd_nxt = txd_r;
    if (bus_driver_fault) txd_nxt = 1'b0;                          // [RQ14]
    else if (!busf_nxt)   txd_nxt = 1'b1;
    if (sel_fall) begin
      snap_nxt = status;                                           // [RQ2]
      shout_nxt = status;
      cnt_nxt = 4'h0;
      oe_nxt = 1'b1;                                               // [RQ2]
      miso_nxt = status[XFER_BITS-1];                              // [RQ22]
    end
    if (sck_rise && cnt_r != 4'h0) begin
      miso_nxt = shout_r[XFER_BITS-1];                             // [RQ3]
    end
    if (sck_fall) begin
      shin_nxt = {shin_r[6:0], s2_r[0]};                           // [RQ3] [RQ22]
      shout_nxt = {shout_r[6:0], 1'b0};
      if (cnt_r != 4'hf) cnt_nxt = cnt_r + 4'h1;
    end
    if (sel_rise) oe_nxt = 1'b0;                                   // [RQ5]
    if (good) begin
      ctl_nxt = shin_r;                                            // [RQ5] [RQ1]
      pu_nxt = shin_r[CTL_PULLUP];                                 // [RQ8]
      wdc_nxt = (op_t'(shin_r[1:0]) == OP_WDCLR);                  // [RQ10]
      if (shin_r[7:6] == SLEW_LOWPOWER && shin_r[4:2] == 3'h0 && !shin_r[1]) begin
        if (armed_r && last_r == shin_r) begin                     // [RQ11]
          sleep_nxt = !shin_r[0];
          stop_nxt = shin_r[0];
          armed_nxt = 1'b0;
        end else begin
          armed_nxt = 1'b1;
        end
      end else begin
        armed_nxt = 1'b0;
        sleep_nxt = 1'b0;
        stop_nxt = 1'b0;
      end
      last_nxt = shin_r;
    end
    // a hot switch drops all three enables; a later write restores them
    if (switch_hot) ctl_nxt[CTL_SW3:CTL_SW1] = 3'h0;               // [RQ19] [RQ20]
  end

  // power-on reset alone owns the pullup bit
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) pu_r <= 1'b0;                                      // [RQ6]
    else pu_r <= pu_nxt;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shin_r <= 8'h00; shout_r <= 8'h00; snap_r <= 8'h00;
      cnt_r <= 4'h0; ctl_r <= CTL_RESET;                           // [RQ6]
      last_r <= 8'h00; armed_r <= 1'b0; first_r <= 1'b1;
      wdc_r <= 1'b0; sleep_r <= 1'b0; stop_r <= 1'b0;
      busf_r <= 1'b0; ov_r <= 1'b0; uv_r <= 1'b0; bf_r <= 1'b0;
      rt_r <= 1'b0; sw_r <= 1'b0; wk_r <= 1'b0; wc_r <= 2'h0;
      txd_r <= 1'b1; miso_r <= 1'b0; oe_r <= 1'b0;
    end else begin
      shin_r <= shin_nxt; shout_r <= shout_nxt; snap_r <= snap_nxt;
      cnt_r <= cnt_nxt; ctl_r <= ctl_nxt;
      last_r <= last_nxt; armed_r <= armed_nxt; first_r <= first_nxt;
      wdc_r <= wdc_nxt; sleep_r <= sleep_nxt; stop_r <= stop_nxt;
      busf_r <= busf_nxt; ov_r <= ov_nxt; uv_r <= uv_nxt; bf_r <= bf_nxt;
      rt_r <= rt_nxt; sw_r <= sw_nxt; wk_r <= wk_nxt; wc_r <= wc_nxt;
      txd_r <= txd_nxt; miso_r <= miso_nxt; oe_r <= oe_nxt;
    end
  end

  assign link.miso_o  = miso_r;
  assign link.miso_oe = oe_r;                                      // [RQ5]
  assign slew_sel              = ctl_r[CTL_SLEW_HI:CTL_SLEW_LO];   // [RQ7]
  assign slew_lowpower_req     = (slew_t'(ctl_r[7:6]) == SLEW_LP); // [RQ7]
  assign bus_pullup_disconnect = pu_r;                             // [RQ8]
  assign switch_one_enable     = ctl_r[CTL_SW1];                   // [RQ9]
  assign switch_two_enable     = ctl_r[CTL_SW2];                   // [RQ9]
  assign switch_three_enable   = ctl_r[CTL_SW3];                   // [RQ9]
  assign sleep_req             = sleep_r;                          // [RQ10]
  assign stop_req              = stop_r;                           // [RQ10]
  assign watchdog_clear        = wdc_r;                            // [RQ10]
  assign bus_tx_enable         = txd_r;                            // [RQ14]
endmodule
`default_nettype wire

// >>> hdl/mcu_spi_ctrl.sv
// Purpose: controller end: wishbone registers drive one-byte transfers
// Assumes: classic wishbone, one-cycle ack
// Notes:   link clock is clk divided by 2*(div+1)
`timescale 1ns/1ps
`default_nettype none
module mcu_spi_ctrl
  import ctl_spi_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  ctl_spi_if.ctrl          link
);
  import ctl_spi_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOW  = 2'b01,
    ST_HIGH = 2'b10,
    ST_END  = 2'b11
  } cst_t;

  cst_t       st_r, st_nxt;
  logic [7:0] tx_r, tx_nxt, rx_r, rx_nxt, div_r, div_nxt, dc_r, dc_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic       sck_r, sck_nxt, ss_r, ss_nxt, mo_r, mo_nxt, ack_r, ack_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic       m1_r, m2_r;
  wire        req = wb_cyc_i & wb_stb_i & ~ack_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      m1_r <= 1'b1;
      m2_r <= 1'b1;
    end else begin
      m1_r <= link.miso;
      m2_r <= m1_r;
    end
  end

  always_comb begin
    st_nxt = st_r; tx_nxt = tx_r; rx_nxt = rx_r; div_nxt = div_r;
    dc_nxt = dc_r; bit_nxt = bit_r; sck_nxt = sck_r; ss_nxt = ss_r;
    mo_nxt = mo_r; ack_nxt = req; rd_nxt = rd_r;
    if (req) begin
      unique case (wb_adr_i)
        WB_STAT_OFS: rd_nxt = {23'h0, st_r != ST_IDLE, rx_r};
        WB_DIV_OFS:  rd_nxt = {24'h0, div_r};
        default:     rd_nxt = 32'h0;
      endcase
      if (wb_we_i && wb_sel_i[0]) begin
        if (wb_adr_i == WB_DIV_OFS) div_nxt = wb_dat_i[7:0];
        // a command while busy is dropped
        if (wb_adr_i == WB_CMD_OFS && st_r == ST_IDLE) begin
          tx_nxt = wb_dat_i[7:0];
          ss_nxt = 1'b0;
          mo_nxt = wb_dat_i[7];                                    // [RQ22]
          bit_nxt = 4'h0;
          dc_nxt = 8'h0;
          st_nxt = ST_LOW;
        end
      end
    end
    if (st_r != ST_IDLE) begin
      // data in is taken one clock after the falling link clock: the answer
      // crosses the die's synchroniser and ours, so a sample on the fall
      // itself would still see the previous bit; needs div of 4 or more
      if ((st_r == ST_LOW || st_r == ST_END) && dc_r == 8'h0 && bit_r != 4'h0) begin
        rx_nxt = {rx_r[6:0], m2_r};                                // [RQ3]
      end
      dc_nxt = dc_r + 8'h1;
      if (dc_r == div_r) begin
        dc_nxt = 8'h0;
        unique case (st_r)
          ST_LOW: begin
            sck_nxt = 1'b1;                                        // [RQ3]
            if (bit_r != 4'h0) mo_nxt = tx_r[7];
            st_nxt = ST_HIGH;
          end
          ST_HIGH: begin
            sck_nxt = 1'b0;
            tx_nxt = {tx_r[6:0], 1'b0};
            bit_nxt = bit_r + 4'h1;
            st_nxt = (bit_r == 4'h7) ? ST_END : ST_LOW;            // [RQ1] [RQ4]
          end
          ST_END: begin
            ss_nxt = 1'b1;                                         // [RQ5]
            st_nxt = ST_IDLE;
          end
          default: st_nxt = ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= ST_IDLE; tx_r <= 8'h00; rx_r <= 8'h00; div_r <= DIV_RESET;
      dc_r <= 8'h00; bit_r <= 4'h0; sck_r <= 1'b0; ss_r <= 1'b1;
      mo_r <= 1'b0; ack_r <= 1'b0; rd_r <= 32'h0;
    end else begin
      st_r <= st_nxt; tx_r <= tx_nxt; rx_r <= rx_nxt; div_r <= div_nxt;
      dc_r <= dc_nxt; bit_r <= bit_nxt; sck_r <= sck_nxt; ss_r <= ss_nxt;
      mo_r <= mo_nxt; ack_r <= ack_nxt; rd_r <= rd_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rd_r;
  assign link.select_n = ss_r;
  assign link.serial_clock_in = sck_r;
  assign link.mosi = mo_r;
endmodule
`default_nettype wire

// >>> sim/ctl_spi_asserts.sv
// Purpose: wire-level checks of the control byte link between both ends
// Assumes: clk samples the link; both ends are design code
// Notes:   sample edges of each frame are counted in helper logic
`timescale 1ns/1ps
`default_nettype none
module ctl_spi_asserts (
  input wire logic clk,
  input wire logic resetn,
  input wire logic select_n,
  input wire logic serial_clock_in,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic miso
);
  logic       sck_r;
  logic       sck_nxt;
  logic [3:0] falls_r;
  logic [3:0] falls_nxt;
  always_comb begin
    sck_nxt   = serial_clock_in;
    falls_nxt = select_n ? 4'h0 : falls_r + {3'h0, sck_r & ~serial_clock_in};
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sck_r   <= 1'h0;
      falls_r <= 4'h0;
    end else begin
      sck_r   <= sck_nxt;
      falls_r <= falls_nxt;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // sync delay of the die is a few clocks, hence the window
  a_drive_on_start: assert property ($fell(select_n) |-> ##[1:5] miso_oe)
    else $error("data out not driven after select fall");
  a_float_on_end: assert property ($rose(select_n) |-> ##[1:5] !miso_oe)
    else $error("data out still driven after select rise");
  a_float_idle: assert property (select_n [*6] |-> !miso_oe)
    else $error("data out driven while deselected");
  a_clock_idle: assert property (select_n |-> !serial_clock_in)
    else $error("serial clock high outside frame");
  a_mosi_at_sample: assert property ($fell(serial_clock_in) |-> $stable(mosi))
    else $error("mosi moved at sample edge");
  a_miso_at_sample: assert property ($fell(serial_clock_in) && miso_oe |-> $stable(miso_o))
    else $error("miso moved at sample edge");
  a_eight_edges: assert property ($rose(select_n) |-> falls_r == 4'h8)
    else $error("frame without exactly eight sample edges");
  a_frame_gap: assert property ($rose(select_n) |=> select_n [*3])
    else $error("select high too short between frames");
endmodule
`default_nettype wire

// >>> sim/tb_analog_die_spi_slave_regs.sv
// Purpose: both ends joined; wishbone orders transfers, die events are driven
// Assumes: busy in the status register covers the whole frame
// Notes:   event pulses last two clocks so the die cannot miss them
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %0t got %h exp %h", $time, (g), (e)); end end
module tb_analog_die_spi_slave_regs;
  import ctl_spi_pkg::*;
  logic        clk;
  logic        resetn;
  logic        por_n;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [3:0]  adr;
  logic [31:0] wdat;
  logic [3:0]  sel;
  logic [31:0] rdat;
  logic        ack;
  logic [8:0]  evt;
  logic [1:0]  slew;
  logic        lp, pud, sw1, sw2, sw3, slp, stp, wdc, txe;
  logic [7:0]  s;
  logic [31:0] q;
  int          fail_count;
  int          checked;
  int          wd_n;
  int          n;
  ctl_spi_if lnk ();
  analog_die_spi_slave_regs analog_die_spi_slave_regs_i (
    .clk(clk), .resetn(resetn), .por_n(por_n), .link(lnk),
    .bus_wake(evt[0]), .bus_driver_fault(evt[1]), .overvoltage(evt[2]),
    .undervoltage(evt[3]), .battery_fail(evt[4]), .regulator_hot(evt[5]),
    .switch_hot(evt[6]), .wake_input_one(1'h1), .wake_input_two(1'h0),
    .wake_by_one(evt[7]), .wake_by_two(evt[8]), .slew_sel(slew), .slew_lowpower_req(lp),
    .bus_pullup_disconnect(pud), .switch_one_enable(sw1), .switch_two_enable(sw2),
    .switch_three_enable(sw3), .sleep_req(slp), .stop_req(stp), .watchdog_clear(wdc),
    .bus_tx_enable(txe));
  mcu_spi_ctrl mcu_spi_ctrl_i (
    .clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
    .link(lnk));
  ctl_spi_asserts ctl_spi_asserts_i (
    .clk(clk), .resetn(resetn), .select_n(lnk.select_n),
    .serial_clock_in(lnk.serial_clock_in), .mosi(lnk.mosi), .miso_o(lnk.miso_o),
    .miso_oe(lnk.miso_oe), .miso(lnk.miso));
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    @(posedge clk);
    cyc <= 1'h1; stb <= 1'h1; we <= w; adr <= a; wdat <= d; sel <= 4'h1;
    do @(posedge clk); while (ack !== 1'h1);
    r = rdat;
    cyc <= 1'h0; stb <= 1'h0; sel <= 4'h0;
  endtask
  task automatic xfer(input logic [7:0] c, output logic [7:0] st);
    logic [31:0] r;
    wb(1'h1, WB_CMD_OFS, {24'h0, c}, r);
    repeat (4) @(posedge clk);
    r = 32'h100;
    while (r[8] !== 1'h0) wb(1'h0, WB_STAT_OFS, 32'h0, r);
    st = r[7:0];
    repeat (8) @(posedge clk);
  endtask
  task automatic pulse(input logic [8:0] m);
    @(posedge clk);
    evt <= m;
    repeat (2) @(posedge clk);
    evt <= 9'h0;
    repeat (6) @(posedge clk);
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (wdc === 1'h1) wd_n++;
  initial begin
    // long enough for about six hundred transfers at the default divider
    repeat (60000) @(posedge clk);
    fail_count++;
    end_sim;
  end
  initial begin
    resetn = 1'h0; por_n = 1'h0; cyc = 1'h0; stb = 1'h0; we = 1'h0;
    adr = 4'h0; wdat = 32'h0; sel = 4'h0; evt = 9'h010; fail_count = 0; checked = 0; wd_n = 0;
    repeat (12) @(posedge clk);
    resetn <= 1'h1; por_n <= 1'h1;
    @(posedge clk);
    `CHK({sw3, sw2, sw1, slew, txe}, 6'h01)
    wb(1'h0, 4'hc, 32'h0, q);
    `CHK(q, 32'h0)
    xfer(8'hbf, s);
    `CHK(s[4], 1'h1)
    `CHK({slew, sw3, sw2, sw1}, 5'h17)
    evt <= 9'h0;
    resetn <= 1'h0;
    repeat (3) @(posedge clk);
    `CHK({slew, sw3, sw2, sw1, pud}, 6'h01)
    resetn <= 1'h1;
    for (int i = 0; i < 3; i++) begin
      xfer({i[1:0], 6'h0b}, s);
      `CHK({slew, sw2, sw1}, {i[1:0], 2'h2})
    end
    n = wd_n;
    xfer(8'h02, s);
    `CHK(wd_n - n, 1)
    xfer(8'h1f, s);
    pulse(9'h040);
    `CHK({sw3, sw2, sw1}, 3'h0)
    xfer(8'h03, s);
    `CHK(s[2], 1'h1)
    xfer(8'h1f, s);
    `CHK({s[2], sw3, sw2, sw1}, 4'h7)
    pulse(9'h02c);
    xfer(8'h03, s);
    `CHK(s[5:3], 3'h7)
    xfer(8'h03, s);
    `CHK(s[5:3], 3'h0)
    pulse(9'h002);
    `CHK(txe, 1'h0)
    xfer(8'h03, s);
    `CHK(s[6], 1'h1)
    `CHK(txe, 1'h1)
    pulse(9'h101);
    xfer(8'h03, s);
    `CHK({s[7:6], s[1:0]}, 4'he)
    xfer(8'h03, s);
    `CHK({s[7:6], s[1:0]}, 4'h1)
    xfer(8'he0, s);
    `CHK(slp, 1'h0)
    xfer(8'he0, s);
    `CHK({slp, stp, pud, lp}, 4'hb)
    xfer(8'h03, s);
    `CHK({slp, lp}, 2'h0)
    xfer(8'hc1, s);
    xfer(8'hc1, s);
    `CHK({stp, slp, pud}, 3'h4)
    xfer(8'h03, s);
    `CHK(stp, 1'h0)
    end_sim;
  end
endmodule
`default_nettype wire
